// >>> hdl/fcsm_pkg.sv
package fcsm_pkg;

  // Flash bus widths.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // Command addresses and codes used in the command write sequences.
  localparam logic [14:0] UNLOCK_ADDR_1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_2 = 15'h2AAA;
  localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;

  // Identification read addresses (low bits only).
  localparam logic [7:0] ID_MAKER_ADDR = 8'h00;
  localparam logic [7:0] ID_PART_ADDR = 8'h01;
  localparam logic [7:0] ID_PROTECT_ADDR = 8'h02;

  // Bit positions.
  localparam int TOP_DATA_BIT = 7;
  localparam int TIME_LIMIT_FLAG_BIT = 5;
  localparam int LOWEST_DATA_BIT = 0;
  localparam int SECTOR_SELECT_LOW_BIT = 16;

  // Bus cycle timing, in 5 ns clock cycles.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC);
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
  localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC);

  // Sector erase accumulation window: 80 us at 200 MHz.
  localparam int ERASE_WINDOW_US = 80;
  localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int MAX_QUEUED_SECTORS = 8;
  localparam logic [3:0] QUEUE_RESET = 4'h0;

  // Host operations.
  typedef enum logic [2:0] {
    fcsm_op_reset,
    fcsm_op_ident,
    fcsm_op_program,
    fcsm_op_chip_erase,
    fcsm_op_sector_erase,
    fcsm_op_suspend,
    fcsm_op_resume,
    fcsm_op_read
  } fcsm_op_e;

  // One host request.
  typedef struct packed {
    fcsm_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcsm_req_s;

  // One bus cycle handed to the pin engine.
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcsm_cycle_s;

  // Flash pin group.
  typedef struct packed {
    logic ce_b;
    logic we_b;
    logic oe_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } fcsm_pins_s;

endpackage

// >>> hdl/fcsm_bus_cycle.sv
`timescale 1ns/1ps
module fcsm_bus_cycle
  import fcsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Cycle request.
  input wire logic start,
  input wire fcsm_cycle_s cycle,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // Flash pins.
  output fcsm_pins_s pins,
  input wire logic [DATA_W-1:0] dq_in
);

  typedef enum {bc_idle, bc_setup, bc_strobe, bc_hold} fcsm_bc_e;

  fcsm_bc_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  fcsm_pins_s pins_r, pins_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;

  // Read data comes from off chip, so it passes two flops first.
  always_ff @(posedge clk) begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
  end

  // Address stands before both strobes fall and data stands until both rise. [RULE3]
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      bc_idle: begin
        if (start) begin
          pins_nxt.addr = cycle.addr;
          pins_nxt.dq_out = cycle.data;
          pins_nxt.dq_oe = cycle.write;
          cnt_nxt = SETUP_CNT;
          state_nxt = bc_setup;
        end
      end
      bc_setup: begin
        if (cnt_r <= 8'h01) begin
          pins_nxt.ce_b = 1'b0;
          pins_nxt.we_b = ~pins_r.dq_oe;
          pins_nxt.oe_b = pins_r.dq_oe;
          cnt_nxt = STROBE_CNT;
          state_nxt = bc_strobe;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      bc_strobe: begin
        if (cnt_r <= 8'h01) begin
          rdata_nxt = dq_s2_r;
          pins_nxt.ce_b = 1'b1;
          pins_nxt.we_b = 1'b1;
          pins_nxt.oe_b = 1'b1;
          cnt_nxt = HOLD_CNT;
          state_nxt = bc_hold;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      bc_hold: begin
        if (cnt_r <= 8'h01) begin
          pins_nxt.dq_oe = 1'b0;
          done_nxt = 1'b1;
          state_nxt = bc_idle;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: state_nxt = bc_idle;
    endcase
  end

  // Registers of the cycle engine.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= bc_idle;
      cnt_r <= 8'h00;
      pins_r <= '{ce_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
      done_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pins = pins_r;
  assign done = done_r;
  assign rdata = rdata_r;

endmodule

// >>> hdl/fcsm_host.sv
// Behaviour
// (RULE1) Upper address bits ignored in command cycles.
// (RULE2) Resume suspended erase with 30H anywhere.
// (RULE3) Address on later fall, data earlier rise.
// (RULE4) Sector chosen only by address bits 18-16.
// (RULE5) Read/reset returns array reads thereafter.
// (RULE6) Power-up lands in read mode.
// (RULE7) Ident reads 00H maker, 01H part.
// (RULE8) Ident bytes have odd parity.
// (RULE9) Ident read 02H shows sector protection.
// (RULE10) Host writes read/reset to leave ident.
// (RULE11) Program is four write cycles.
// (RULE12) Programming starts on data cycle rise.
// (RULE13) Poll top bit at programmed address.
// (RULE14) Command writes ignored while programming.
// (RULE15) Program only clears ones to zeros.
// (RULE16) Chip erase is six write cycles.
// (RULE17) Chip erase preprograms then erases sectors.
// (RULE18) Chip erase done when top bit one.
// (RULE19) Sector erase six cycles, command 30H.
// (RULE20) Erase starts 80 us after last write.
// (RULE21) Other command in window aborts queue.
// (RULE22) Only suspend/resume during erase; poll inside.
// (RULE23) Sequences open with AAH/5555H, 55H/2AAAH.
// (RULE24) Suspend/resume valid only in sector erase.
// (RULE25) Top bit shows busy status while running.
// (RULE26) Command codes F0, 90, A0, 80, 10, 30.
`timescale 1ns/1ps
module fcsm_host
  import fcsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // User request port.
  input wire logic req_valid,
  input wire fcsm_req_s req,
  output logic req_ready,
  // User answer port.
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_data,
  output logic resp_fail,
  // Flash pins.
  output logic flash_ce_b,
  output logic flash_we_b,
  output logic flash_oe_b,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_in
);

  typedef enum {st_idle, st_issue, st_wait, st_poll, st_done} fcsm_st_e;

  fcsm_st_e state_r, state_nxt;
  fcsm_req_s cur_r, cur_nxt;
  logic [2:0] step_r, step_nxt;
  logic [2:0] nsteps_r, nsteps_nxt;
  logic ready_r, ready_nxt;
  logic resp_valid_r, resp_valid_nxt;
  logic [DATA_W-1:0] resp_data_r, resp_data_nxt;
  logic resp_fail_r, resp_fail_nxt;
  logic bc_start_r, bc_start_nxt;
  fcsm_cycle_s bc_cycle_r, bc_cycle_nxt;
  logic bc_done;
  logic [DATA_W-1:0] bc_rdata;
  fcsm_pins_s pins;

  // Builds one command write; unlock addresses use only the low 15 bits. [RULE1]
  function automatic fcsm_cycle_s cmd_wr(input logic [14:0] a, input logic [7:0] d);
    cmd_wr = '{write: 1'b1, addr: {4'h0, a}, data: d};
  endfunction

  // Nth write of each command sequence. [RULE23] [RULE26]
  function automatic fcsm_cycle_s seq_cycle(input fcsm_req_s r, input logic [2:0] n);
    seq_cycle = cmd_wr(UNLOCK_ADDR_1, UNLOCK_DATA_1);
    case (n)
      3'h0: begin
        if (r.op == fcsm_op_suspend) begin
          seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_SUSPEND); // [RULE24]
        end else if (r.op == fcsm_op_resume) begin
          seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_RESUME); // [RULE2]
        end else if (r.op == fcsm_op_read) begin
          seq_cycle = '{write: 1'b0, addr: r.addr, data: 8'h00}; // [RULE5]
        end
      end
      3'h1, 3'h4: seq_cycle = cmd_wr(UNLOCK_ADDR_2, UNLOCK_DATA_2);
      3'h2: begin
        case (r.op)
          fcsm_op_reset: seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_RESET); // [RULE10]
          fcsm_op_ident: seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_IDENT);
          fcsm_op_program: seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_PROGRAM);
          default: seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_ERASE_SETUP);
        endcase
      end
      3'h3: begin
        if (r.op == fcsm_op_program) begin
          seq_cycle = '{write: 1'b1, addr: r.addr, data: r.data}; // [RULE11] [RULE12]
        end
      end
      3'h5: begin
        if (r.op == fcsm_op_chip_erase) begin
          seq_cycle = cmd_wr(UNLOCK_ADDR_1, CMD_CHIP_ERASE); // [RULE16]
        end else begin
          // Only the sector select bits matter in the sector cycle. [RULE4] [RULE19]
          seq_cycle = '{write: 1'b1, addr: {r.addr[ADDR_W-1:SECTOR_SELECT_LOW_BIT],
                        16'h0000}, data: CMD_SECTOR_ERASE};
        end
      end
      default: seq_cycle = cmd_wr(UNLOCK_ADDR_1, UNLOCK_DATA_1);
    endcase
  endfunction

  // Number of bus cycles in each sequence; the sequencer cuts ident and read/reset to three.
  function automatic logic [2:0] seq_len(input fcsm_op_e op);
    case (op)
      fcsm_op_program, fcsm_op_ident, fcsm_op_reset: seq_len = 3'h4;
      fcsm_op_chip_erase, fcsm_op_sector_erase: seq_len = 3'h6;
      default: seq_len = 3'h1;
    endcase
  endfunction

  // Sequencer: issue each cycle, then for program and erase poll the top data bit until done.
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    step_nxt = step_r;
    nsteps_nxt = nsteps_r;
    ready_nxt = 1'b0;
    resp_valid_nxt = 1'b0;
    resp_data_nxt = resp_data_r;
    resp_fail_nxt = resp_fail_r;
    bc_start_nxt = 1'b0;
    bc_cycle_nxt = bc_cycle_r;
    case (state_r)
      st_idle: begin
        ready_nxt = 1'b1;
        if (req_valid && ready_r) begin
          ready_nxt = 1'b0;
          cur_nxt = req;
          // The ident sequence sends only three writes; then the read comes in.
          nsteps_nxt = (req.op == fcsm_op_ident || req.op == fcsm_op_reset) ? 3'h3
                       : seq_len(req.op);
          step_nxt = 3'h0;
          resp_fail_nxt = 1'b0;
          state_nxt = st_issue;
        end
      end
      st_issue: begin
        bc_cycle_nxt = seq_cycle(cur_r, step_r);
        bc_start_nxt = 1'b1;
        state_nxt = st_wait;
      end
      st_wait: begin
        if (bc_done) begin
          resp_data_nxt = bc_rdata;
          if (step_r + 3'h1 < nsteps_r) begin
            step_nxt = step_r + 3'h1;
            state_nxt = st_issue;
          end else if (cur_r.op == fcsm_op_program || cur_r.op == fcsm_op_chip_erase ||
                       cur_r.op == fcsm_op_sector_erase) begin
            // Poll read of the target; the program address is still held in cur_r. [RULE13] [RULE22]
            bc_cycle_nxt = '{write: 1'b0, addr: cur_r.addr, data: 8'h00};
            bc_start_nxt = 1'b1;
            state_nxt = st_poll;
          end else begin
            state_nxt = st_done;
          end
        end
      end
      st_poll: begin
        // No new command is sent while the operation runs. [RULE14] [RULE17] [RULE20]
        if (bc_done) begin
          resp_data_nxt = bc_rdata;
          if ((cur_r.op == fcsm_op_program &&
               bc_rdata[TOP_DATA_BIT] == cur_r.data[TOP_DATA_BIT]) ||
              (cur_r.op != fcsm_op_program && bc_rdata[TOP_DATA_BIT])) begin // [RULE18] [RULE25]
            state_nxt = st_done;
          end else if (bc_rdata[TIME_LIMIT_FLAG_BIT]) begin
            resp_fail_nxt = 1'b1; // [RULE15]
            state_nxt = st_done;
          end else begin
            bc_start_nxt = 1'b1;
          end
        end
      end
      st_done: begin
        resp_valid_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = st_idle;
      end
      default: state_nxt = st_idle;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= st_idle;
      cur_r <= '{op: fcsm_op_reset, addr: '0, data: '0};
      step_r <= 3'h0;
      nsteps_r <= 3'h0;
      ready_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_data_r <= 8'h00;
      resp_fail_r <= 1'b0;
      bc_start_r <= 1'b0;
      bc_cycle_r <= '{write: 1'b0, addr: '0, data: '0};
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      step_r <= step_nxt;
      nsteps_r <= nsteps_nxt;
      ready_r <= ready_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_data_r <= resp_data_nxt;
      resp_fail_r <= resp_fail_nxt;
      bc_start_r <= bc_start_nxt;
      bc_cycle_r <= bc_cycle_nxt;
    end
  end

  // Pin timing engine.
  fcsm_bus_cycle u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .start(bc_start_r),
    .cycle(bc_cycle_r),
    .done(bc_done),
    .rdata(bc_rdata),
    .pins(pins),
    .dq_in(flash_dq_in)
  );

  // Outputs; pin values are flops inside the cycle engine.
  assign req_ready = ready_r;
  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;
  assign resp_fail = resp_fail_r;
  assign flash_ce_b = pins.ce_b;
  assign flash_we_b = pins.we_b;
  assign flash_oe_b = pins.oe_b;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe = pins.dq_oe;

endmodule

// >>> bench/fcsm_host_asserts.sv
`timescale 1ns/1ps
module fcsm_host_asserts
  import fcsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // User side.
  input wire logic req_valid,
  input wire fcsm_req_s req,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [DATA_W-1:0] resp_data,
  input wire logic resp_fail,
  // Flash pins.
  input wire logic flash_ce_b,
  input wire logic flash_we_b,
  input wire logic flash_oe_b,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_in
);
  // All checks use the bus clock and sleep in reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic take;
  // A request is accepted on this edge.
  assign take = req_valid && req_ready;
  a_strobe_excl: assert property (flash_we_b || flash_oe_b)
    else $error("write and read strobes low together");
  a_we_in_ce: assert property (!flash_we_b |-> !flash_ce_b)
    else $error("write strobe without chip select");
  a_we_width: assert property ($fell(flash_we_b) |-> !flash_we_b[*8] ##1 flash_we_b)
    else $error("write strobe width wrong");
  a_addr_hold: assert property (!flash_we_b && !$fell(flash_we_b) |->
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in a write");
  a_dq_setup: assert property ($fell(flash_we_b) |-> $past(flash_dq_oe, 4))
    else $error("data not set up before write strobe");
  a_read_no_dq: assert property (!flash_oe_b |-> !flash_dq_oe)
    else $error("host drives data during a read");
  a_unlock_first: assert property (take && req.op == fcsm_op_program |-> ##[1:12]
    (!flash_we_b && flash_addr[14:0] == UNLOCK_ADDR_1 && flash_dq_out == UNLOCK_DATA_1))
    else $error("sequence does not open with unlock write");
  a_resp_pulse: assert property (resp_valid |-> req_ready ##1 !resp_valid)
    else $error("completion pulse too long");
  c_program: cover property (take && req.op == fcsm_op_program);
  c_ident: cover property (take && req.op == fcsm_op_ident);
  c_fail: cover property (resp_valid && resp_fail);
endmodule
bind fcsm_host fcsm_host_asserts u_chk (.clk, .rst_b, .req_valid, .req, .req_ready,
  .resp_valid, .resp_data, .resp_fail, .flash_ce_b, .flash_we_b, .flash_oe_b,
  .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in);

// >>> bench/fcsm_flash_model.sv
`timescale 1ns/1ps
module fcsm_flash_model
  import fcsm_pkg::*;
#(
  parameter int WIN = 16000,
  parameter int PROG_CYC = 40,
  parameter int ERASE_CYC = 200,
  parameter logic [7:0] MAKER_ID = 8'h3D, // Arbitrary value.
  parameter logic [7:0] PART_ID = 8'h52, // Arbitrary value.
  parameter logic [7:0] PROT = 8'h04
)(
  // Timer clock.
  input wire logic clk,
  // Flash pins.
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout
);
  logic [7:0] mem [logic [18:0]];
  logic [18:0] la;
  logic [7:0] pv, rv, last;
  logic [2:0] sec;
  logic ident, tl;
  int s, kind, cnt;
  wire wr = !ce_b && !we_b;
  // Unwritten bytes read as erased.
  function automatic logic [7:0] rd_mem(logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Power up idle in read mode.
  initial begin
    s = 0;
    kind = 0;
    cnt = 0;
    ident = 0;
    tl = 0;
    last = 8'h00;
  end
  // Address is taken as the write strobes fall, which raises the active-high write term.
  always @(posedge wr) la = addr;
  // Data decode on the rising strobe; only low 15 bits matter in commands.
  always @(negedge wr) begin
    if (kind == 0 || (tl && din == CMD_RESET)) begin
      if (s != 6 && din == CMD_RESET) begin
        s = 0;
        ident = 0;
        kind = 0;
        tl = 0;
      end else case (s)
        0, 3: s = (la[14:0] == UNLOCK_ADDR_1 && din == UNLOCK_DATA_1) ? s + 1 : 0;
        1, 4: s = (la[14:0] == UNLOCK_ADDR_2 && din == UNLOCK_DATA_2) ? s + 1 : 0;
        2: begin
          ident = la[14:0] == UNLOCK_ADDR_1 && din == CMD_IDENT;
          s = la[14:0] != UNLOCK_ADDR_1 ? 0 : din == CMD_PROGRAM ? 6 :
            din == CMD_ERASE_SETUP ? 3 : 0;
        end
        5: begin
          sec = la[18:16];
          kind = din == CMD_CHIP_ERASE ? 2 : din == CMD_SECTOR_ERASE ? 3 : 0;
          cnt = kind == 3 ? WIN + ERASE_CYC : ERASE_CYC;
          s = 0;
        end
        default: begin
          pv = din;
          tl = (din & ~rd_mem(la)) != 0;
          mem[la] = din & rd_mem(la);
          kind = 1;
          cnt = PROG_CYC;
          s = 0;
        end
      endcase
    end else if (kind == 3 && cnt > ERASE_CYC) begin
      // A further sector command restarts the window; any other command except suspend drops the queue.
      if (din == CMD_SECTOR_ERASE) cnt = WIN + ERASE_CYC;
      else if (din != CMD_SUSPEND) kind = 0;
    end
  end
  // Internal algorithm timer; a time-limit fault never ends by itself.
  always @(posedge clk) begin
    if (kind != 0 && !tl && cnt > 0) cnt = cnt - 1;
    else if (kind != 0 && !tl) begin
      foreach (mem[k]) if (kind == 2 || (kind == 3 && k[18:16] == sec)) mem[k] = 8'hFF;
      kind = 0;
    end
    if (!ce_b && !oe_b) last = rv;
  end
  // Read data: status while busy, codes in ident mode, else the array.
  always @* begin
    if (kind == 1) rv = {~pv[7], 1'b0, tl, pv[4:0]};
    else if (kind != 0) rv = 8'h00;
    else if (ident) rv = addr[7:0] == ID_MAKER_ADDR ? MAKER_ID :
      addr[7:0] == ID_PART_ADDR ? PART_ID : {7'h00, PROT[addr[18:16]]};
    else rv = rd_mem(addr);
  end
  // A deselected bus shows the inverse of the last byte, never a held value.
  assign dout = (!ce_b && !oe_b) ? rv : ~last;
endmodule

// >>> bench/flash_command_state_machine_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module flash_command_state_machine_tb
  import fcsm_pkg::*;
;
  localparam int WIN = 16000;
  localparam logic [7:0] MAKER = 8'h3D; // Arbitrary value.
  localparam logic [7:0] PART = 8'h52; // Arbitrary value.
  logic clk, rst_b, req_valid, req_ready, resp_valid, resp_fail;
  fcsm_req_s req;
  logic [7:0] resp_data, dq_out, dq_in;
  logic ce_b, we_b, oe_b, dq_oe;
  logic [18:0] fa;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  // Host under test and flash model.
  fcsm_host dut (.clk, .rst_b, .req_valid, .req, .req_ready, .resp_valid, .resp_data,
    .resp_fail, .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b), .flash_addr(fa),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  fcsm_flash_model #(.WIN(WIN), .MAKER_ID(MAKER), .PART_ID(PART)) u_flash (.clk,
    .ce_b, .we_b, .oe_b, .addr(fa), .din(dq_out), .dout(dq_in));
  // Clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Ends the run with the verdict.
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One request, held until taken, then wait for completion.
  task automatic run(input fcsm_op_e o, input logic [18:0] a, input logic [7:0] d);
    req = '{op: o, addr: a, data: d};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30000) error_cnt++;
  endtask
  // Power-up reads, then program and read back.
  task automatic t_program;
    run(fcsm_op_read, 19'h12345, 8'h00);
    `CHK(resp_data, 8'hFF)
    run(fcsm_op_program, 19'h12345, 8'h5A);
    `CHK(resp_fail, 1'b0)
    run(fcsm_op_read, 19'h12345, 8'h00);
    `CHK(resp_data, 8'h5A)
    $display("test program done");
  endtask
  // Identification codes, protection bit, then leave with read/reset.
  task automatic t_ident;
    run(fcsm_op_ident, 19'h00000, 8'h00);
    run(fcsm_op_read, 19'h70000, 8'h00);
    `CHK(resp_data, MAKER)
    `CHK(^resp_data, 1'b1)
    run(fcsm_op_read, 19'h50001, 8'h00);
    `CHK(resp_data, PART)
    run(fcsm_op_read, 19'h20002, 8'h00);
    `CHK(resp_data[0], 1'b1)
    run(fcsm_op_read, 19'h30002, 8'h00);
    `CHK(resp_data[0], 1'b0)
    run(fcsm_op_reset, 19'h00000, 8'h00);
    run(fcsm_op_read, 19'h12345, 8'h00);
    `CHK(resp_data, 8'h5A)
    $display("test ident done");
  endtask
  // Setting a zero back to one ends in the time-limit fault.
  task automatic t_fail;
    run(fcsm_op_program, 19'h12345, 8'hA5);
    `CHK(resp_fail, 1'b1)
    run(fcsm_op_reset, 19'h00000, 8'h00);
    run(fcsm_op_read, 19'h12345, 8'h00);
    `CHK(resp_data, 8'h00)
    $display("test fail done");
  endtask
  // Sector erase spares other sectors; chip erase clears all.
  task automatic t_erase;
    run(fcsm_op_program, 19'h20000, 8'h00);
    run(fcsm_op_sector_erase, 19'h12345, 8'h00);
    `CHK(n > WIN, 1'b1)
    run(fcsm_op_read, 19'h12345, 8'h00);
    `CHK(resp_data, 8'hFF)
    run(fcsm_op_read, 19'h20000, 8'h00);
    `CHK(resp_data, 8'h00)
    run(fcsm_op_chip_erase, 19'h00000, 8'h00);
    `CHK(resp_data[7], 1'b1)
    run(fcsm_op_read, 19'h20000, 8'h00);
    `CHK(resp_data, 8'hFF)
    $display("test erase done");
  endtask
  // Suspend and resume outside a sector erase are ignored and leave read mode alone.
  task automatic t_suspend;
    run(fcsm_op_suspend, 19'h00000, 8'h00);
    `CHK(resp_fail, 1'b0)
    run(fcsm_op_resume, 19'h00000, 8'h00);
    `CHK(resp_fail, 1'b0)
    run(fcsm_op_read, 19'h20000, 8'h00);
    `CHK(resp_data, 8'hFF)
    $display("test suspend done");
  endtask
  // Watchdog.
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_program;
    t_ident;
    t_fail;
    t_erase;
    t_suspend;
    tally_and_finish;
  end
endmodule
